// ### hdl/asmc_cnt_if.sv
/*
  carrier between the controller and its phase timer.
  assumes one clock shared by both ends.
*/
interface asmc_cnt_if;
  logic       load;   // start a new phase
  logic [3:0] len;    // phase length in cycles
  logic       done;   // phase expired, one cycle pulse
  modport ctrl (output load, output len, input done);
  modport tmr  (input load, input len, output done);
endinterface

// ### hdl/asmc_host.sv
/*
  host controller for a 1m x 4 asynchronous static memory.
  assumes the user side is on clock_i and the memory pins leave through
  pads; data pins arrive asynchronous and are synchronised before use.
*/
`include "asmc_params.svh"
module asmc_host
#(
  parameter int ADDR_W = `ASMC_ADDR_W,
  parameter int DATA_W = `ASMC_DATA_W
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  // user request port
  input  wire logic              req_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic                   busy_o,
  output logic                   rvalid_o,
  output logic [DATA_W-1:0]      rdata_o,
  // memory pins
  output logic                   primary_select_n_o,
  output logic                   secondary_select_o,
  output logic                   out_drive_n_o,
  output logic                   store_strobe_n_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  input  wire logic [DATA_W-1:0] mem_data_i,
  output logic [DATA_W-1:0]      mem_data_o,
  output logic                   mem_data_oe_o
);
  import asmc_pkg::*;

  // ==========================================================
  // declarations
  asmc_state_t       state_q;     // phase
  logic [DATA_W-1:0] sync1_q;     // first sync stage, read only by sync2
  logic [DATA_W-1:0] sync2_q;     // synchronised data pins
  asmc_cnt_if        cnt ();      // timer carrier
  logic              ld_q;        // timer load pulse
  logic [3:0]        len_q;       // timer length

  asmc_timer u_timer (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .cnt     (cnt)
  );
  assign cnt.load = ld_q;
  assign cnt.len  = len_q;

  function automatic logic [3:0] cyc4(input int n);
    return n[3:0];
  endfunction

  // ==========================================================
  // data pin synchroniser; the reads are slow enough to allow it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= mem_data_i;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // sequencer, drives every memory pin from a flop
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q            <= ASMC_IDLE;
      primary_select_n_o <= 1'b1;  // standby from reset
      secondary_select_o <= 1'b0;  // second standby term
      out_drive_n_o      <= 1'b1;
      store_strobe_n_o   <= 1'b1;
      mem_addr_o         <= '0;
      mem_data_o         <= '0;
      mem_data_oe_o      <= 1'b0;
      busy_o             <= 1'b0;
      ld_q               <= 1'b0;
      len_q              <= `ASMC_CNT_ZERO;
    end else begin
      ld_q     <= 1'b0;
      case (state_q)
        ASMC_IDLE: begin
          if (req_i) begin
            // address goes out with the select, never after it
            mem_addr_o         <= addr_i;
            primary_select_n_o <= 1'b0;
            secondary_select_o <= 1'b1;
            busy_o             <= 1'b1;
            ld_q               <= 1'b1;
            if (we_i) begin
              // output disable first; device may still be floating out
              out_drive_n_o <= 1'b1;
              mem_data_o    <= wdata_i;
              len_q         <= cyc4(`ASMC_TURN_CYC);
              state_q       <= ASMC_TURN;
            end else begin
              out_drive_n_o    <= 1'b0;
              store_strobe_n_o <= 1'b1;
              len_q            <= cyc4(`ASMC_RD_CYC);
              state_q          <= ASMC_RD;
            end
          end else begin
            busy_o <= 1'b0;
          end
        end
        ASMC_TURN: begin
          if (cnt.done) begin
            // device released, now safe to drive
            mem_data_oe_o    <= 1'b1;
            store_strobe_n_o <= 1'b0;
            ld_q             <= 1'b1;
            len_q            <= cyc4(`ASMC_WR_CYC);
            state_q          <= ASMC_WR;
          end
        end
        ASMC_WR: begin
          if (cnt.done) begin
            // strobe ends the write; select stays low this cycle
            store_strobe_n_o <= 1'b1;
            state_q          <= ASMC_WEND;
          end
        end
        ASMC_WEND: begin
          // data held one cycle past the ending strobe edge
          mem_data_oe_o      <= 1'b0;
          primary_select_n_o <= 1'b1;
          secondary_select_o <= 1'b0;
          busy_o             <= 1'b0;
          state_q            <= ASMC_IDLE;
        end
        ASMC_RD: begin
          if (cnt.done) begin
            if (req_i && !we_i) begin
              // back to back read: selects held, only address moves
              mem_addr_o <= addr_i;
              ld_q       <= 1'b1;
              len_q      <= cyc4(`ASMC_RD_CYC);
            end else begin
              out_drive_n_o      <= 1'b1;
              primary_select_n_o <= 1'b1;
              secondary_select_o <= 1'b0;
              busy_o             <= 1'b0;
              state_q            <= ASMC_IDLE;
            end
          end
        end
        default: begin
          state_q <= ASMC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // read data capture; sync adds two cycles after the sample point
  logic [1:0] rd_dly_q;  // pipeline matching the synchroniser
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_dly_q <= 2'b00;
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
    end else begin
      rd_dly_q <= {rd_dly_q[0], (state_q == ASMC_RD) && cnt.done};
      rvalid_o <= rd_dly_q[1];
      if (rd_dly_q[1]) begin
        rdata_o <= sync2_q;
      end
    end
  end

  // ==========================================================
  // checks
  strobe_in_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == ASMC_RD) |-> store_strobe_n_o) else $error("strobe low in read");
  no_fight_a: assert property (@(posedge clock_i) disable iff (rst_i)
    mem_data_oe_o |-> out_drive_n_o) else $error("bus fight");
  write_overlap_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !store_strobe_n_o |-> !primary_select_n_o && secondary_select_o)
    else $error("strobe outside select");
  data_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(store_strobe_n_o) |-> mem_data_oe_o && $stable(mem_data_o))
    else $error("data not held at write end");
  strobe_first_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(store_strobe_n_o) |-> !primary_select_n_o ##1 primary_select_n_o)
    else $error("write end order");
  addr_before_sel_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(primary_select_n_o) |=> $stable(mem_addr_o))
    else $error("address moved after select");
  idle_standby_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == ASMC_IDLE) && !busy_o |-> primary_select_n_o && !secondary_select_o)
    else $error("idle not standby");
  read_valid_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q == ASMC_RD) && cnt.done |-> ##3 rvalid_o)
    else $error("read result late");
  select_rise_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(primary_select_n_o) |-> $past(store_strobe_n_o))
    else $error("select rose with strobe");
  float_unless_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_q != ASMC_RD) |-> out_drive_n_o)
    else $error("output enabled outside read");
endmodule // asmc_host

// ### hdl/asmc_params.svh
/*
  timing and width constants for the static memory host controller.
  assumes a 10 mhz system clock; every pin phase is counted in cycles.
*/
`ifndef ASMC_PARAMS_SVH
`define ASMC_PARAMS_SVH
// ==========================================================
// widths
`define ASMC_ADDR_W      20
`define ASMC_DATA_W      4
// ==========================================================
// times in ns and the clock period in ns
`define ASMC_CLK_NS      100
`define ASMC_T_RC_NS     12
`define ASMC_T_PWE_NS    7
`define ASMC_T_HZOE_NS   6
// cycles, least times rounded up, at least one cycle
`define ASMC_CYC(ns)     ((((ns) + `ASMC_CLK_NS - 1) / `ASMC_CLK_NS) < 1 ? 1 : \
                          (((ns) + `ASMC_CLK_NS - 1) / `ASMC_CLK_NS))
`define ASMC_RD_CYC      `ASMC_CYC(`ASMC_T_RC_NS)
`define ASMC_WR_CYC      `ASMC_CYC(`ASMC_T_PWE_NS)
`define ASMC_TURN_CYC    `ASMC_CYC(`ASMC_T_HZOE_NS)
`define ASMC_CNT_ZERO    4'h0
`endif

// ### hdl/asmc_pkg.sv
/*
  types for the static memory host controller.
  assumes asmc_params.svh is on the include path.
*/
package asmc_pkg;
  // ==========================================================
  // controller phases
  typedef enum logic [2:0] {
    ASMC_IDLE = 3'b000,  // deselected, bus released
    ASMC_TURN = 3'b001,  // wait for device outputs to float
    ASMC_RD   = 3'b010,  // read access in progress
    ASMC_WR   = 3'b011,  // write strobe low
    ASMC_WEND = 3'b100   // strobe high, data held
  } asmc_state_t;
endpackage

// ### hdl/asmc_timer.sv
/*
  phase timer: counts a loaded length down and pulses done at zero.
  assumes load is a one-cycle pulse from the controller.
*/
module asmc_timer (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // phase control
  asmc_cnt_if.tmr   cnt
);
  `include "asmc_params.svh"
  logic [3:0] count_q;  // remaining cycles
  logic       run_q;    // counting
  logic       done_q;   // expiry pulse
  // ==========================================================
  // countdown
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= `ASMC_CNT_ZERO;
      run_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (cnt.load) begin  // restart always wins
        count_q <= cnt.len - 4'h1;
        run_q   <= 1'b1;
      end else if (run_q) begin
        if (count_q == `ASMC_CNT_ZERO) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end else begin
          count_q <= count_q - 4'h1;
        end
      end
    end
  end
  assign cnt.done = done_q;
endmodule // asmc_timer

// ### verif/asmc_sram_model.sv
/*
  behavioural model of the 1m x 4 static memory on the far side of the host.
  assumes the bench feeds it the host pins and uses its resolved data bus.
*/
`include "asmc_params.svh"
module asmc_sram_model (
  // control pins from the host
  input  wire logic                    primary_select_n_i,
  input  wire logic                    secondary_select_i,
  input  wire logic                    out_drive_n_i,
  input  wire logic                    store_strobe_n_i,
  input  wire logic [`ASMC_ADDR_W-1:0] addr_i,
  // host data drive
  input  wire logic [`ASMC_DATA_W-1:0] host_data_i,
  input  wire logic                    host_oe_i,
  // resolved pins and contention flag
  output logic      [`ASMC_DATA_W-1:0] bus_o,
  output logic                         clash_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // storage and decode
  logic [`ASMC_DATA_W-1:0] mem [logic [`ASMC_ADDR_W-1:0]];  // sparse array
  logic [`ASMC_ADDR_W-1:0] wa_q;                            // write address
  logic [`ASMC_DATA_W-1:0] wd_q, rd, last_q = '0;           // data latches
  int                      wr_cnt = 0;                      // store count
  wire sel = !primary_select_n_i && secondary_select_i;
  wire wr  = sel && !store_strobe_n_i;
  wire drv = sel && !out_drive_n_i && store_strobe_n_i;
  // latch during the overlap, commit at whichever edge ends it
  always @* if (wr) begin
    wa_q = addr_i;
    wd_q = bus_o;
  end
  always @(negedge wr) begin
    mem[wa_q] = wd_q;
    wr_cnt++;
  end
  // read path follows address changes while selected
  always @(addr_i or wr_cnt) rd = mem.exists(addr_i) ? mem[addr_i] : ~addr_i[3:0];
  always @* if (drv) last_q = rd;
  // a floating bus shows the inverse, never a stale match
  assign bus_o   = host_oe_i ? host_data_i : (drv ? rd : ~last_q);
  assign clash_o = host_oe_i && drv;
endmodule  // asmc_sram_model

// ### verif/test_asmc_host.sv
/*
  self-checking bench for the static memory host controller.
  assumes asmc_params.svh on the include path and the memory model beside it.
*/
`include "asmc_params.svh"
module test_asmc_host;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // stimulus and observation
  logic        clock_i = 0, rst_i = 1, req_i = 0, we_i = 0;
  logic [19:0] addr_i = '0, cur_a = '0;
  logic [3:0]  wdata_i = '0, cur_d = '0;
  wire logic   busy_o, rvalid_o, cs_n, cs2, oe_n, we_n, hoe, clash;
  wire logic [3:0]  rdata_o, hdata, bus;
  wire logic [19:0] maddr;
  logic        p_we = 1;                   // strobe one cycle ago
  logic [3:0]  shadow [logic [19:0]];      // expected contents
  logic [19:0] addrs [30];
  int          fails = 0, compares = 0, cyc = 0, i;
  always #50 clock_i = ~clock_i;
  asmc_host asmc_host_i (.clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .we_i(we_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .rvalid_o(rvalid_o),
    .rdata_o(rdata_o), .primary_select_n_o(cs_n), .secondary_select_o(cs2),
    .out_drive_n_o(oe_n), .store_strobe_n_o(we_n), .mem_addr_o(maddr),
    .mem_data_i(bus), .mem_data_o(hdata), .mem_data_oe_o(hoe));
  asmc_sram_model asmc_sram_model_i (.primary_select_n_i(cs_n), .secondary_select_i(cs2),
    .out_drive_n_i(oe_n), .store_strobe_n_i(we_n), .addr_i(maddr), .host_data_i(hdata),
    .host_oe_i(hoe), .bus_o(bus), .clash_o(clash));
  // ==========================================================
  // compares and closing
  task chk4(input logic [3:0] g, input logic [3:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // falling edges from request release to busy low (write) or to rvalid (read)
  function automatic logic [7:0] exp_lat(input logic w);
    return w ? 8'(5 + `ASMC_TURN_CYC + `ASMC_WR_CYC) : 8'(4 + `ASMC_RD_CYC);
  endfunction
  task stop_test;
    $display("counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test;
    end
  end
  // pin watcher: strobe quiet in reads, data held past strobe rise
  always @(negedge clock_i) if (!rst_i) begin
    if (!cs_n && cs2) begin
      chk1(maddr === cur_a, 1'b1);
      if (!oe_n) chk1(we_n, 1'b1);
    end
    if (!p_we && we_n) begin
      chk1(hoe, 1'b1);
      chk4(hdata, cur_d);
    end
    chk1(clash, 1'b0);
    p_we <= we_n;
  end
  // one access, request held one edge, completion waited under a bound
  task xfer(input logic w, input logic [19:0] a, input logic [3:0] d);
    int n;
    n = 0;
    @(negedge clock_i);
    {req_i, we_i, addr_i, wdata_i, cur_a, cur_d} = {1'b1, w, a, d, a, d};
    @(negedge clock_i);
    req_i = 0;
    while ((w ? busy_o !== 1'b0 : rvalid_o !== 1'b1) && n < 50) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 50) begin
      fails++;
      stop_test;
    end else begin
      chk8(8'(n), exp_lat(w));
      if (w) shadow[a] = d;
      else chk4(rdata_o, shadow[a]);
    end
  endtask
  // next read result, always at least one edge on so a standing pulse is not reused
  task await_read(input logic [19:0] a);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (rvalid_o !== 1'b1 && n < 50);
    if (n == 50) begin
      fails++;
      stop_test;
    end else chk4(rdata_o, shadow[a]);
  endtask
  // chained read: request held so the second address is taken at read end
  task chain(input logic [19:0] a, input logic [19:0] b);
    @(negedge clock_i);
    {req_i, we_i, addr_i, cur_a} = {1'b1, 1'b0, a, a};
    repeat (3) @(negedge clock_i);
    addr_i = b;
    cur_a <= b;
    @(negedge clock_i);
    req_i = 0;
    await_read(a);
    await_read(b);
  endtask
  task pins_idle;
    chk1(cs_n, 1'b1);
    chk1(cs2, 1'b0);
    chk1(hoe, 1'b0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h9678308b));
    repeat (2) @(posedge clock_i);
    @(negedge clock_i) rst_i = 0;
    pins_idle;
    $display("test reset done");
    xfer(1, 20'h00000, 4'h0);
    xfer(1, 20'hfffff, 4'hf);
    xfer(1, 20'h00000, 4'ha);  // overwrite, last one must win
    xfer(0, 20'h00000, 4'h0);
    xfer(0, 20'hfffff, 4'h0);
    $display("test corners done");
    for (i = 0; i < 30; i++) begin
      addrs[i] = 20'($urandom);
      xfer(1, addrs[i], 4'($urandom));
    end
    for (i = 0; i < 30; i++) xfer(0, addrs[$urandom % 30], 4'h0);
    $display("test random done");
    chain(addrs[0], addrs[1]);
    chain(20'h00000, 20'hfffff);
    $display("test chained read done");
    @(negedge clock_i) rst_i = 1;
    repeat (2) @(negedge clock_i);
    pins_idle;
    rst_i = 0;
    xfer(0, 20'hfffff, 4'h0);
    $display("test second reset done");
    stop_test;
  end
endmodule  // test_asmc_host
